// [logic/mms_pkg.sv]
// types shared by the mastering and statistics stage
package mms_pkg;

  // --------------------------------------------------------------------------
  // one segment's measured values, signed, one lsb per length unit
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic signed [31:0] edge_a;
    logic signed [31:0] edge_b;
    logic signed [31:0] diameter;
    logic signed [31:0] center;
  } mms_meas_t;

  typedef struct packed {
    logic               en;
    logic [4:0]         src;
    logic signed [31:0] value;
  } mms_mst_cfg_t;

  typedef struct packed {
    logic               en;
    logic [4:0]         src;
    logic [5:0]         len;
  } mms_sta_cfg_t;

  typedef struct packed {
    logic [1:0]         tag;
    logic [3:0]         entry;
    logic signed [31:0] value;
  } mms_out_t;

  typedef enum logic [4:0] {
    MMS_ST_IDLE = 5'b00001,
    MMS_ST_MAST = 5'b00010,
    MMS_ST_LOAD = 5'b00100,
    MMS_ST_SCAN = 5'b01000,
    MMS_ST_EMIT = 5'b10000
  } mms_state_t;

endpackage

// [logic/mms_regs.svh]
// constants of the mastering and statistics stage
`ifndef MMS_REGS_SVH
`define MMS_REGS_SVH

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define MMS_NUM_ENT     10
`define MMS_NUM_SEG     8
`define MMS_WIN_MAX     32
`define MMS_FIFO_DEPTH  8
`define MMS_VAL_W       32

// ----------------------------------------------------------------------------
// source select layout: {segment[2:0], signal kind[1:0]}
// ----------------------------------------------------------------------------
`define MMS_SRC_KIND_LSB 0
`define MMS_SRC_SEG_LSB  2

// ----------------------------------------------------------------------------
// output word tags
// ----------------------------------------------------------------------------
`define MMS_TAG_VAL     2'h0
`define MMS_TAG_MIN     2'h1
`define MMS_TAG_MAX     2'h2
`define MMS_TAG_PP      2'h3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define MMS_RST_OFFSET  32'h0000_0000
`define MMS_ZERO_MASTER 32'h0000_0000

`endif

// [logic/mms_top.sv]
// mastering offsets, sliding window statistics and output buffer
`include "mms_regs.svh"

// ----------------------------------------------------------------------------
// output buffer with registered head
// ----------------------------------------------------------------------------
module mms_fifo #(
  parameter int WIDTH = 38,
  parameter int DEPTH = `MMS_FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic             vld_q;
  logic [WIDTH-1:0] dat_q;
  wire logic        push;
  wire logic        pop;
  wire logic        head_free;

  // the head register adds one word of capacity beyond the array
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign push      = in_valid && in_ready;
  assign head_free = !vld_q || out_ready;
  assign pop       = head_free && (cnt_q != '0);
  assign out_valid = vld_q;
  assign out_data  = dat_q;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      vld_q <= 1'b0;
      dat_q <= '0;
    end else begin
      if (push) begin
        wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q  <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
        dat_q <= mem[rp_q];
        vld_q <= 1'b1;
      end else if (head_free) begin
        vld_q <= 1'b0;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// How it works
// - zeroing is mastering with a master value of zero
// - mastering stores offset so the current measurement reads as the master value
// - mastered outputs are raw value plus a constant offset
// - ten mastering entries, each a source signal and its master value
// - mastered values feed the common output stream for all interfaces
// - mastering acts on one selected entry or on all entries
// - repeated mastering recomputes the offset from the latest measurement
// - master reset clears the offset, restoring unmastered output
// - multi-segment preset selects edge a, edge b, diameter, center of segments 1 to 8
// - other presets select edge a, edge b, diameter, center only
// - statistics use only values inside the entry's evaluation window
// - each new value enters the window, the oldest leaves, results refresh
// - each statistics entry yields minimum, maximum and span
// - ten statistics entries, each with source and window length
// - an inactive statistics entry computes nothing
// - statistics reset acts on one selected entry or on all
// - statistics reset clears results, restarting from the next value
// - statistics results are sent in the output stream
// - statistics run on every measurement, independent of output triggers
module mms_top #(
  parameter int NUM_ENT = `MMS_NUM_ENT,
  parameter int WIN_MAX = `MMS_WIN_MAX,
  parameter int FDEPTH  = `MMS_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                     CLOCK_IN,
  input  wire logic                     ARST_N_IN,
  // measured values from the calculation stage
  input  wire logic                     SMP_VALID_IN,
  input  wire mms_pkg::mms_meas_t [7:0] SMP_DATA_IN,
  output logic                          SMP_READY_OUT,
  input  wire logic                     MULTI_SEG_IN,
  // mastering configuration and commands
  input  wire logic                     MST_CFG_WR_IN,
  input  wire logic [3:0]               MST_CFG_IDX_IN,
  input  wire mms_pkg::mms_mst_cfg_t    MST_CFG_IN,
  input  wire logic                     MST_EXEC_IN,
  input  wire logic                     MST_CLR_IN,
  input  wire logic                     MST_ALL_IN,
  input  wire logic [3:0]               MST_SEL_IN,
  output logic [NUM_ENT-1:0]            MST_APPLIED_OUT,
  // statistics configuration and commands
  input  wire logic                     STA_CFG_WR_IN,
  input  wire logic [3:0]               STA_CFG_IDX_IN,
  input  wire mms_pkg::mms_sta_cfg_t    STA_CFG_IN,
  input  wire logic                     STA_CLR_IN,
  input  wire logic                     STA_ALL_IN,
  input  wire logic [3:0]               STA_SEL_IN,
  // result stream to the output interfaces
  output logic                          OUT_VALID_OUT,
  output mms_pkg::mms_out_t             OUT_DATA_OUT,
  input  wire logic                     OUT_READY_IN
);
  localparam int WA = $clog2(WIN_MAX);
  localparam int HA = $clog2(NUM_ENT*WIN_MAX);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  mms_pkg::mms_state_t   st_q;
  mms_pkg::mms_meas_t [7:0] last_q;
  mms_pkg::mms_mst_cfg_t mcfg_q [NUM_ENT];
  logic signed [31:0]    off_q  [NUM_ENT];
  mms_pkg::mms_sta_cfg_t scfg_q [NUM_ENT];
  logic [WA-1:0]         wp_q   [NUM_ENT];
  logic [WA:0]           fill_q [NUM_ENT];
  logic [31:0]           hist   [NUM_ENT*WIN_MAX];
  logic [3:0]            idx_q;
  logic [WA:0]           k_q;
  logic [1:0]            sub_q;
  logic signed [31:0]    min_q;
  logic signed [31:0]    max_q;

  // source selection, segment index forced to 0 (segment 1) outside multi-segment preset
  function automatic logic signed [31:0] pick(input mms_pkg::mms_meas_t [7:0] s,
                                              input logic [4:0] src,
                                              input logic multi);
    logic [2:0] seg;
    seg = multi ? src[`MMS_SRC_SEG_LSB +: 3] : 3'h0;
    case (src[`MMS_SRC_KIND_LSB +: 2])
      2'h0:    pick = s[seg].edge_a;
      2'h1:    pick = s[seg].edge_b;
      2'h2:    pick = s[seg].diameter;
      default: pick = s[seg].center;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // combinational decode
  // --------------------------------------------------------------------------
  wire logic        is_idle  = (st_q == mms_pkg::MMS_ST_IDLE);
  wire logic        is_mast  = (st_q == mms_pkg::MMS_ST_MAST);
  wire logic        is_load  = (st_q == mms_pkg::MMS_ST_LOAD);
  wire logic        is_scan  = (st_q == mms_pkg::MMS_ST_SCAN);
  wire logic        is_emit  = (st_q == mms_pkg::MMS_ST_EMIT);
  wire logic        last_ent = (idx_q == 4'(NUM_ENT-1));
  wire logic        m_en     = mcfg_q[idx_q].en;
  wire logic        s_en     = scfg_q[idx_q].en;
  wire logic        f_ready;
  wire logic        take     = is_idle && SMP_VALID_IN;
  wire logic signed [31:0] m_raw = pick(last_q, mcfg_q[idx_q].src, MULTI_SEG_IN);
  wire logic signed [31:0] m_val = m_raw + off_q[idx_q];
  wire logic signed [31:0] s_val = pick(last_q, scfg_q[idx_q].src, MULTI_SEG_IN);
  wire logic [5:0]  len_raw  = scfg_q[idx_q].len;
  wire logic [WA:0] len_eff  = (len_raw == 6'h00) ? (WA+1)'(1) :
                               ((32'(len_raw) > WIN_MAX) ? (WA+1)'(WIN_MAX) :
                                (WA+1)'(len_raw));
  wire logic [WA:0] fill_cur = fill_q[idx_q];
  wire logic [HA-1:0] h_base = HA'(32'(idx_q) * WIN_MAX);
  wire logic [HA-1:0] h_wr   = h_base + HA'(wp_q[idx_q]);
  wire logic [HA-1:0] h_rd   = h_base + HA'(k_q);
  wire logic signed [31:0] h_val = hist[h_rd];
  wire logic        scan_end = (k_q + 1'b1 >= fill_cur);
  wire logic signed [31:0] span = max_q - min_q;

  // result word: mastered value or one of the three statistics
  wire logic        push = (is_mast && m_en) || is_emit;
  wire logic [1:0]  tag  = is_mast ? `MMS_TAG_VAL :
                           (sub_q == 2'h0) ? `MMS_TAG_MIN :
                           (sub_q == 2'h1) ? `MMS_TAG_MAX : `MMS_TAG_PP;
  wire logic signed [31:0] word_v = is_mast ? m_val :
                                    (sub_q == 2'h0) ? min_q :
                                    (sub_q == 2'h1) ? max_q : span;
  wire mms_pkg::mms_out_t word = '{tag: tag, entry: idx_q, value: word_v};
  wire logic        adv  = !push || f_ready;

  // --------------------------------------------------------------------------
  // sequencer: one pass per measurement, stalls on a full buffer
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_q  <= mms_pkg::MMS_ST_IDLE;
      idx_q <= 4'h0;
      k_q   <= '0;
      sub_q <= 2'h0;
      min_q <= 32'sh0;
      max_q <= 32'sh0;
    end else begin
      case (st_q)
        mms_pkg::MMS_ST_IDLE: begin
          idx_q <= 4'h0;
          if (SMP_VALID_IN) begin
            st_q <= mms_pkg::MMS_ST_MAST;
          end
        end
        mms_pkg::MMS_ST_MAST: begin
          if (adv) begin
            idx_q <= last_ent ? 4'h0 : idx_q + 4'h1;
            if (last_ent) begin
              st_q <= mms_pkg::MMS_ST_LOAD;
            end
          end
        end
        mms_pkg::MMS_ST_LOAD: begin
          k_q   <= '0;
          min_q <= s_val;
          max_q <= s_val;
          if (s_en) begin
            st_q <= mms_pkg::MMS_ST_SCAN;
          end else if (last_ent) begin
            st_q <= mms_pkg::MMS_ST_IDLE;
          end else begin
            idx_q <= idx_q + 4'h1;
          end
        end
        mms_pkg::MMS_ST_SCAN: begin
          if (k_q < fill_cur) begin
            if (h_val < min_q) begin
              min_q <= h_val;
            end
            if (h_val > max_q) begin
              max_q <= h_val;
            end
          end
          k_q <= k_q + 1'b1;
          if (scan_end) begin
            sub_q <= 2'h0;
            st_q  <= mms_pkg::MMS_ST_EMIT;
          end
        end
        mms_pkg::MMS_ST_EMIT: begin
          if (f_ready) begin
            sub_q <= sub_q + 2'h1;
            if (sub_q == 2'h2) begin
              sub_q <= 2'h0;
              if (last_ent) begin
                st_q <= mms_pkg::MMS_ST_IDLE;
              end else begin
                idx_q <= idx_q + 4'h1;
                st_q  <= mms_pkg::MMS_ST_LOAD;
              end
            end
          end
        end
        default: begin
          st_q <= mms_pkg::MMS_ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // latest measurement, kept for mastering between samples
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      last_q <= '0;
    end else if (take) begin
      last_q <= SMP_DATA_IN;
    end
  end

  // --------------------------------------------------------------------------
  // mastering entries and offsets
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (int i = 0; i < NUM_ENT; i++) begin
        mcfg_q[i] <= '0;
        off_q[i]  <= `MMS_RST_OFFSET;
      end
      MST_APPLIED_OUT <= '0;
    end else begin
      for (int i = 0; i < NUM_ENT; i++) begin
        if (MST_CFG_WR_IN && (MST_CFG_IDX_IN == 4'(i))) begin
          mcfg_q[i]          <= MST_CFG_IN;
          off_q[i]           <= `MMS_RST_OFFSET;
          MST_APPLIED_OUT[i] <= 1'b0;
        end else if ((MST_ALL_IN || (MST_SEL_IN == 4'(i))) && mcfg_q[i].en) begin
          if (MST_CLR_IN) begin
            off_q[i]           <= `MMS_RST_OFFSET;
            MST_APPLIED_OUT[i] <= 1'b0;
          end else if (MST_EXEC_IN) begin
            // a master value of zero is plain zeroing
            off_q[i] <= mcfg_q[i].value -
                        pick(last_q, mcfg_q[i].src, MULTI_SEG_IN);
            MST_APPLIED_OUT[i] <= 1'b1;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // statistics entries and window bookkeeping
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_IN) begin
    if (is_load && s_en) begin
      hist[h_wr] <= s_val;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      for (int i = 0; i < NUM_ENT; i++) begin
        scfg_q[i] <= '0;
        wp_q[i]   <= '0;
        fill_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_ENT; i++) begin
        if (STA_CFG_WR_IN && (STA_CFG_IDX_IN == 4'(i))) begin
          scfg_q[i] <= STA_CFG_IN;
          wp_q[i]   <= '0;
          fill_q[i] <= '0;
        end else if (STA_CLR_IN && (STA_ALL_IN || (STA_SEL_IN == 4'(i)))) begin
          // window restarts empty; the next sample begins a new set
          wp_q[i]   <= '0;
          fill_q[i] <= '0;
        end else if (is_load && s_en && (idx_q == 4'(i))) begin
          // oldest slot is overwritten once the window is full
          wp_q[i]   <= (WA+1)'(wp_q[i]) + 1'b1 >= len_eff ? '0 : wp_q[i] + 1'b1;
          fill_q[i] <= (fill_q[i] >= len_eff) ? len_eff : fill_q[i] + 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // output buffer
  // --------------------------------------------------------------------------
  mms_fifo #(
    .WIDTH ($bits(mms_pkg::mms_out_t)),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .clk       (CLOCK_IN),
    .arst_n    (ARST_N_IN),
    .in_valid  (push),
    .in_data   (word),
    .in_ready  (f_ready),
    .out_valid (OUT_VALID_OUT),
    .out_data  (OUT_DATA_OUT),
    .out_ready (OUT_READY_IN)
  );

  // ready is the idle state bit itself, so it comes straight from a flop
  assign SMP_READY_OUT = st_q[0];

endmodule

// [verification/mms_chk_sva.sv]
// port assertions for the mastering and statistics stage
`include "mms_regs.svh"
module mms_chk #(
  parameter int NUM_ENT = 10
) (
  input wire logic               CLOCK_IN,
  input wire logic               ARST_N_IN,
  input wire logic               SMP_VALID_IN,
  input wire logic               SMP_READY_OUT,
  input wire logic               MST_CFG_WR_IN,
  input wire logic [3:0]         MST_CFG_IDX_IN,
  input wire logic               MST_CLR_IN,
  input wire logic               MST_ALL_IN,
  input wire logic [3:0]         MST_SEL_IN,
  input wire logic [NUM_ENT-1:0] MST_APPLIED_OUT,
  input wire logic               OUT_VALID_OUT,
  input wire mms_pkg::mms_out_t  OUT_DATA_OUT,
  input wire logic               OUT_READY_IN
);
  timeunit 1ns / 1ns;
  wire logic          acc = OUT_VALID_OUT & OUT_READY_IN;
  logic [1:0]         tag_q;
  logic [3:0]         ent_q;
  logic signed [31:0] min_q;
  logic signed [31:0] max_q;
  // ---------------------------------------------------------------------------
  // last accepted word
  // ---------------------------------------------------------------------------
  always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      tag_q <= `MMS_TAG_VAL;
      ent_q <= 4'h0;
      min_q <= 32'h0;
      max_q <= 32'h0;
    end else if (acc) begin
      tag_q <= OUT_DATA_OUT.tag;
      ent_q <= OUT_DATA_OUT.entry;
      if (OUT_DATA_OUT.tag == `MMS_TAG_MIN) min_q <= OUT_DATA_OUT.value;
      if (OUT_DATA_OUT.tag == `MMS_TAG_MAX) max_q <= OUT_DATA_OUT.value;
    end
  end
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!ARST_N_IN);
  sequence s_take;
    SMP_VALID_IN && SMP_READY_OUT;
  endsequence
  sequence s_word(logic [1:0] t);
    acc && OUT_DATA_OUT.tag == t;
  endsequence
  property p_take;
    s_take |=> !SMP_READY_OUT;
  endproperty
  property p_pass_ends;
    s_take |-> ##[2:1000] SMP_READY_OUT;
  endproperty
  property p_out_hold;
    OUT_VALID_OUT && !OUT_READY_IN |=> OUT_VALID_OUT && $stable(OUT_DATA_OUT);
  endproperty
  property p_max_order;
    s_word(`MMS_TAG_MAX) |-> tag_q == `MMS_TAG_MIN && ent_q == OUT_DATA_OUT.entry;
  endproperty
  property p_pp_order;
    s_word(`MMS_TAG_PP) |-> tag_q == `MMS_TAG_MAX && ent_q == OUT_DATA_OUT.entry;
  endproperty
  property p_pp_value;
    s_word(`MMS_TAG_PP) |-> OUT_DATA_OUT.value == max_q - min_q;
  endproperty
  property p_span_sign;
    s_word(`MMS_TAG_MAX) |-> OUT_DATA_OUT.value >= min_q;
  endproperty
  property p_clr_all;
    MST_CLR_IN && MST_ALL_IN |=> MST_APPLIED_OUT == '0;
  endproperty
  property p_clr_one;
    MST_CLR_IN && !MST_ALL_IN && MST_SEL_IN < NUM_ENT |=> !MST_APPLIED_OUT[$past(MST_SEL_IN)];
  endproperty
  property p_cfg_clears;
    MST_CFG_WR_IN && MST_CFG_IDX_IN < NUM_ENT |=> !MST_APPLIED_OUT[$past(MST_CFG_IDX_IN)];
  endproperty
  a_take: assert property (p_take) else $error("sample taken but ready stayed high");
  a_pass_ends: assert property (p_pass_ends) else $error("pass did not finish");
  a_out_hold: assert property (p_out_hold) else $error("stalled word changed");
  a_max_order: assert property (p_max_order) else $error("max not after min");
  a_pp_order: assert property (p_pp_order) else $error("span not after max");
  a_pp_value: assert property (p_pp_value) else $error("span is not max minus min");
  a_span_sign: assert property (p_span_sign) else $error("max below min");
  a_clr_all: assert property (p_clr_all) else $error("offsets left after clear all");
  a_clr_one: assert property (p_clr_one) else $error("offset left after clear");
  a_cfg_clears: assert property (p_cfg_clears) else $error("offset kept on write");
endmodule

bind mms_top mms_chk #(.NUM_ENT(NUM_ENT)) u_chk (
  .CLOCK_IN(CLOCK_IN), .ARST_N_IN(ARST_N_IN), .SMP_VALID_IN(SMP_VALID_IN),
  .SMP_READY_OUT(SMP_READY_OUT), .MST_CFG_WR_IN(MST_CFG_WR_IN),
  .MST_CFG_IDX_IN(MST_CFG_IDX_IN), .MST_CLR_IN(MST_CLR_IN), .MST_ALL_IN(MST_ALL_IN),
  .MST_SEL_IN(MST_SEL_IN), .MST_APPLIED_OUT(MST_APPLIED_OUT),
  .OUT_VALID_OUT(OUT_VALID_OUT), .OUT_DATA_OUT(OUT_DATA_OUT), .OUT_READY_IN(OUT_READY_IN)
);

// [verification/mms_sink.sv]
// downstream output interface model that stalls and records accepted words
module mms_sink (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // stall request from the bench
  input  wire logic              hold_in,
  // result stream
  input  wire logic              valid_in,
  input  wire mms_pkg::mms_out_t data_in,
  output logic                   ready_out
);
  timeunit 1ns / 1ns;
  logic [1:0]        cnt_q;
  mms_pkg::mms_out_t got[$];
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // stalls one cycle in four so the buffer also sees slow drains
  assign ready_out = !hold_in && cnt_q != 2'h3;
  always @(posedge clk_in) begin
    if (arst_n_in && valid_in && ready_out) begin
      got.push_back(data_in);
    end
  end
endmodule

// [verification/tb.sv]
// self-checking bench for the mastering and statistics stage
`include "mms_regs.svh"
module tb;
  timeunit 1ns / 1ns;
  logic clk, arst_n, smp_valid, multi, mst_wr, mst_exec, mst_clr, mst_all;
  logic sta_wr, sta_clr, sta_all, hold, smp_ready, out_valid, out_ready;
  logic [3:0] mst_idx, mst_sel, sta_idx, sta_sel;
  logic [9:0] applied, app_exp;
  mms_pkg::mms_meas_t [7:0] smp;
  mms_pkg::mms_mst_cfg_t mst_cfg;
  mms_pkg::mms_sta_cfg_t sta_cfg;
  mms_pkg::mms_out_t out_data;
  mms_pkg::mms_out_t expq[$];
  logic signed [31:0] moff[10], mval[10], hist[10][$];
  logic [4:0] msrc[10], ssrc[10];
  logic men[10], sen[10];
  int slen[10];
  int miscompares, comparisons;
  logic signed [31:0] bases[8] = '{50, -20, 300, 7, 120, -90, 40, 210};
  mms_top DUT (.CLOCK_IN(clk), .ARST_N_IN(arst_n), .SMP_VALID_IN(smp_valid),
    .SMP_DATA_IN(smp), .SMP_READY_OUT(smp_ready), .MULTI_SEG_IN(multi),
    .MST_CFG_WR_IN(mst_wr), .MST_CFG_IDX_IN(mst_idx), .MST_CFG_IN(mst_cfg),
    .MST_EXEC_IN(mst_exec), .MST_CLR_IN(mst_clr), .MST_ALL_IN(mst_all), .MST_SEL_IN(mst_sel),
    .MST_APPLIED_OUT(applied), .STA_CFG_WR_IN(sta_wr), .STA_CFG_IDX_IN(sta_idx),
    .STA_CFG_IN(sta_cfg), .STA_CLR_IN(sta_clr), .STA_ALL_IN(sta_all), .STA_SEL_IN(sta_sel),
    .OUT_VALID_OUT(out_valid), .OUT_DATA_OUT(out_data), .OUT_READY_IN(out_ready));
  mms_sink sink (.clk_in(clk), .arst_n_in(arst_n), .hold_in(hold), .valid_in(out_valid),
    .data_in(out_data), .ready_out(out_ready));
  // ---------------------------------------------------------------------------
  // compares and closing
  // ---------------------------------------------------------------------------
  task chk_word(input string name, input mms_pkg::mms_out_t e, input mms_pkg::mms_out_t g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask
  task chk_bits(input string name, input logic [9:0] e, input logic [9:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask
  task conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // reference model and access tasks
  // ---------------------------------------------------------------------------
  function automatic logic signed [31:0] raw(input logic [4:0] src);
    mms_pkg::mms_meas_t m;
    m = smp[multi ? src[4:2] : 3'h0];
    case (src[1:0])
      2'h0: raw = m.edge_a;
      2'h1: raw = m.edge_b;
      2'h2: raw = m.diameter;
      default: raw = m.center;
    endcase
  endfunction
  task mst_set(input logic [3:0] i, input logic [4:0] s, input logic signed [31:0] v);
    @(negedge clk);
    mst_wr = 1'b1;
    mst_idx = i;
    mst_cfg = '{1'b1, s, v};
    @(negedge clk);
    mst_wr = 1'b0;
    {men[i], msrc[i], mval[i], moff[i], app_exp[i]} = {1'b1, s, v, 32'h0, 1'b0};
  endtask
  task sta_set(input logic [3:0] i, input logic e, input logic [4:0] s, input logic [5:0] l);
    @(negedge clk);
    sta_wr = 1'b1;
    sta_idx = i;
    sta_cfg = '{e, s, l};
    @(negedge clk);
    sta_wr = 1'b0;
    sen[i] = e;
    ssrc[i] = s;
    slen[i] = (l == 6'h0) ? 1 : (l > 6'h20) ? 32 : int'(l);
    hist[i].delete();
  endtask
  task mst_cmd(input logic ex, input logic cl, input logic al, input logic [3:0] sel);
    @(negedge clk);
    {mst_exec, mst_clr, mst_all, mst_sel} = {ex, cl, al, sel};
    @(negedge clk);
    {mst_exec, mst_clr, mst_all} = 3'h0;
    for (int i = 0; i < 10; i++) begin
      if (al || i == sel) begin
        if (cl) {moff[i], app_exp[i]} = 33'h0;
        else if (ex && men[i]) {moff[i], app_exp[i]} = {mval[i] - raw(msrc[i]), 1'b1};
      end
    end
    @(negedge clk);
    chk_bits("applied", app_exp, applied);
  endtask
  task sta_cmd(input logic al, input logic [3:0] sel);
    @(negedge clk);
    {sta_clr, sta_all, sta_sel} = {1'b1, al, sel};
    @(negedge clk);
    {sta_clr, sta_all} = 2'h0;
    for (int i = 0; i < 10; i++) if (al || i == sel) hist[i].delete();
  endtask
  task pass(input logic signed [31:0] b);
    int n;
    logic signed [31:0] lo, hi;
    for (int s = 0; s < 8; s++) smp[s] = '{b + s * 64, b + s * 64 + 1, 2 * b - s, s * 3 - b};
    @(negedge clk);
    {smp_valid, hold} = 2'h3;
    for (int i = 0; i < 10; i++) if (men[i]) expq.push_back('{`MMS_TAG_VAL, 4'(i), raw(msrc[i]) + moff[i]});
    for (int i = 0; i < 10; i++) begin
      if (sen[i]) begin
        hist[i].push_back(raw(ssrc[i]));
        if (hist[i].size() > slen[i]) void'(hist[i].pop_front());
        lo = hist[i][0];
        hi = lo;
        for (int k = 0; k < hist[i].size(); k++) begin
          if (hist[i][k] < lo) lo = hist[i][k];
          if (hist[i][k] > hi) hi = hist[i][k];
        end
        expq.push_back('{`MMS_TAG_MIN, 4'(i), lo});
        expq.push_back('{`MMS_TAG_MAX, 4'(i), hi});
        expq.push_back('{`MMS_TAG_PP, 4'(i), hi - lo});
      end
    end
    @(negedge clk);
    smp_valid = 1'b0;
    repeat (40) @(negedge clk);
    hold = 1'b0;
    n = 0;
    while ((sink.got.size() < expq.size() || smp_ready !== 1'b1) && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk_bits("count", {1'b1, 9'(expq.size())}, {smp_ready, 9'(sink.got.size())});
    foreach (expq[k]) chk_word("stream word", expq[k], k < sink.got.size() ? sink.got[k] : 'x);
    expq.delete();
    sink.got.delete();
  endtask
  // ---------------------------------------------------------------------------
  // clock, watchdog and test sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #(100 * 20000);
    miscompares++;
    $display("unexpected run length expected finish seen hang");
    conclude;
  end
  initial begin
    {arst_n, smp_valid, mst_wr, mst_exec, mst_clr, mst_all, sta_wr, sta_clr, sta_all} = 9'h0;
    {multi, hold, mst_idx, mst_sel, sta_idx, sta_sel, app_exp} = {2'h3, 16'h0, 10'h0};
    {smp, mst_cfg, sta_cfg} = '0;
    for (int i = 0; i < 10; i++) {men[i], sen[i], moff[i]} = 34'h0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    chk_bits("applied after reset", 10'h0, applied);
    mst_set(4'h0, 5'h02, 32'sd100);
    mst_set(4'h1, 5'h0b, 32'h0);
    mst_set(4'h9, 5'h1d, -32'sd5);
    sta_set(4'h0, 1'b1, 5'h00, 6'h03);
    sta_set(4'h3, 1'b1, 5'h06, 6'h00);
    sta_set(4'h9, 1'b1, 5'h1f, 6'h28);
    for (int p = 0; p < 8; p++) begin
      case (p)
        2: mst_cmd(1'b1, 1'b0, 1'b1, 4'h0);
        3: begin
          mst_cmd(1'b1, 1'b0, 1'b0, 4'h0);
          mst_cmd(1'b1, 1'b0, 1'b0, 4'h5);
        end
        4: mst_cmd(1'b1, 1'b1, 1'b0, 4'h9);
        5: sta_cmd(1'b0, 4'h0);
        6: begin
          sta_cmd(1'b1, 4'h0);
          mst_cmd(1'b0, 1'b1, 1'b1, 4'h0);
        end
        7: begin
          @(negedge clk);
          multi = 1'b0;
          sta_set(4'h3, 1'b0, 5'h06, 6'h00);
        end
        default: ;
      endcase
      pass(bases[p]);
    end
    conclude;
  end
endmodule
